// ===== hdl/fvse_pkg.sv
/*
 * constants for the primary value status encoder: status byte layout,
 * quality, sub-status and limit codes, indicator and identifier timing.
 * assumes a 250 MHz core clock.
 */
package fvse_pkg;

   // =========================================================
   // status byte layout
   localparam int QUAL_MSB = 7;
   localparam int QUAL_LSB = 6;
   localparam int SUB_MSB  = 5;
   localparam int SUB_LSB  = 2;
   localparam int LIM_MSB  = 1;
   localparam int LIM_LSB  = 0;

   // =========================================================
   // quality codes
   localparam logic [1:0] Q_BAD     = 2'h0;
   localparam logic [1:0] Q_UNCERT  = 2'h1;
   localparam logic [1:0] Q_GOOD_NC = 2'h2;
   localparam logic [1:0] Q_GOOD_C  = 2'h3;

   // =========================================================
   // bad sub-status
   localparam logic [3:0] BS_NONSPEC   = 4'h0;
   localparam logic [3:0] BS_CONFIG    = 4'h1;
   localparam logic [3:0] BS_NOT_LINK  = 4'h2;
   localparam logic [3:0] BS_DEV_FAIL  = 4'h3;
   localparam logic [3:0] BS_SENS_FAIL = 4'h4;
   localparam logic [3:0] BS_COMM_LAST = 4'h5;
   localparam logic [3:0] BS_COMM_NONE = 4'h6;
   localparam logic [3:0] BS_OOS       = 4'h7;

   // =========================================================
   // uncertain sub-status
   localparam logic [3:0] US_NONSPEC   = 4'h0;
   localparam logic [3:0] US_LAST_USE  = 4'h1;
   localparam logic [3:0] US_SUBST     = 4'h2;
   localparam logic [3:0] US_INITIAL   = 4'h3;
   localparam logic [3:0] US_SENS_CONV = 4'h4;
   localparam logic [3:0] US_RANGE     = 4'h5;
   localparam logic [3:0] US_SUBNORMAL = 4'h6;

   // =========================================================
   // good non-cascade sub-status and critical alarm priority threshold
   localparam logic [3:0] GS_NONE       = 4'h0;
   localparam logic [3:0] GS_ACT_BLOCK  = 4'h1;
   localparam logic [3:0] GS_ACT_ADV    = 4'h2;
   localparam logic [3:0] GS_ACT_CRIT   = 4'h3;
   localparam logic [3:0] GS_UNACK_BLK  = 4'h4;
   localparam logic [3:0] GS_UNACK_ADV  = 4'h5;
   localparam logic [3:0] GS_UNACK_CRIT = 4'h6;
   localparam logic [3:0] ALARM_CRIT_PRIO = 4'h8;

   // =========================================================
   // limit codes
   localparam logic [1:0] LIM_NONE  = 2'h0;
   localparam logic [1:0] LIM_LOW   = 2'h1;
   localparam logic [1:0] LIM_HIGH  = 2'h2;
   localparam logic [1:0] LIM_CONST = 2'h3;

   // =========================================================
   // timing
   localparam int CLK_PERIOD_NS   = 4;
   localparam int BLINK_HALF_MS   = 250;
   localparam int BLINK_HALF_CYC  = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;
   localparam int ID_BIT_NS       = 1000;
   localparam int ID_BIT_CYC      = (ID_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NODE_ID_W       = 48;
   localparam int VALUE_W         = 16;

   // status byte held in reset: bad, non-specific, no limits
   localparam logic [7:0] STATUS_RST = 8'h00;

endpackage

// ===== hdl/fvse_blink.sv
/*
 * free-running square wave for the flashing green indicator.
 * assumes nothing beyond the core clock and synchronous reset.
 */
`timescale 1ns/1ns
module fvse_blink #(
   parameter int HALF_CYC = 62500000
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic srst,
   // square wave
   output logic      blink_r
);

   // =========================================================
   // half period counter
   logic [31:0] cnt_r;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_r   <= 32'h0;
         blink_r <= 1'b0;
      end else if (cnt_r == 32'(HALF_CYC - 1)) begin
         cnt_r   <= 32'h0;
         blink_r <= ~blink_r;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end

endmodule

// ===== hdl/fvse_id_sender.sv
/*
 * serial sender for the unique node identifier, msb first, one bit per
 * bit time. assumes start is a one-cycle pulse; starts while busy are ignored.
 */
`timescale 1ns/1ns
module fvse_id_sender #(
   parameter int WIDTH   = 48,
   parameter int BIT_CYC = 250
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             srst,
   // request
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] node_id,
   // serial output
   output logic                  busy_r,
   output logic                  tx_bit_r,
   output logic                  tx_strobe_r
);

   // =========================================================
   // shifter
   logic [WIDTH-1:0] shift_r;
   logic [7:0]       bits_left_r;
   logic [15:0]      tick_r;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         busy_r      <= 1'b0;
         shift_r     <= '0;
         bits_left_r <= 8'h0;
         tick_r      <= 16'h0;
         tx_bit_r    <= 1'b0;
         tx_strobe_r <= 1'b0;
      end else begin
         tx_strobe_r <= 1'b0;
         if (!busy_r) begin
            if (start) begin
               busy_r      <= 1'b1;
               shift_r     <= node_id;
               bits_left_r <= 8'(WIDTH);
               tick_r      <= 16'h0;
            end
         end else if (tick_r == 16'(BIT_CYC - 1)) begin
            tick_r      <= 16'h0;
            tx_bit_r    <= shift_r[WIDTH-1];
            tx_strobe_r <= 1'b1;
            shift_r     <= {shift_r[WIDTH-2:0], 1'b0};
            bits_left_r <= bits_left_r - 8'h1;
            if (bits_left_r == 8'h1) begin
               busy_r <= 1'b0;
            end
         end else begin
            tick_r <= tick_r + 16'h1;
         end
      end
   end

endmodule

// ===== hdl/fvse_top.sv
/*
 * primary value status encoder with indicators, commissioning identifier
 * sender, simulate and write protect gating.
 * assumes all condition inputs are synchronous levels and request inputs
 * are one-cycle pulses on core_clk.
 */
`timescale 1ns/1ns
module fvse_top #(
   parameter int                             BLINK_HALF_CYC  = fvse_pkg::BLINK_HALF_CYC,
   parameter logic [fvse_pkg::NODE_ID_W-1:0] UNIQUE_NODE_ID  = 48'h0a1b2c3d4e5f  // arbitrary
) (
   // clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         srst,
   // measured value
   input  wire logic [fvse_pkg::VALUE_W-1:0] primary_measured_value,
   // bad conditions
   input  wire logic                         blk_oos,
   input  wire logic                         dev_fail,
   input  wire logic                         sens_fail,
   input  wire logic                         cfg_err,
   input  wire logic                         not_linked,
   input  wire logic                         comm_lost,
   input  wire logic                         comm_never,
   input  wire logic                         bad_other,
   // uncertain conditions
   input  wire logic                         at_sens_limit,
   input  wire logic                         low_accuracy,
   input  wire logic                         range_viol,
   input  wire logic                         subnormal,
   input  wire logic                         initial_val,
   input  wire logic                         substitute,
   input  wire logic                         last_usable,
   input  wire logic                         uncert_other,
   // limit direction
   input  wire logic                         lim_low,
   input  wire logic                         lim_high,
   input  wire logic                         lim_const,
   // good value and alarms
   input  wire logic                         cascade,
   input  wire logic                         alarm_active,
   input  wire logic                         alarm_unack,
   input  wire logic                         alarm_is_block,
   input  wire logic [3:0]                   alarm_prio,
   // indicators sources
   input  wire logic                         dev_error,
   input  wire logic                         dev_warning,
   // commissioning
   input  wire logic                         commission_req,
   // simulate and write protect
   input  wire logic                         ff_jumper,
   input  wire logic                         sim_req_sw,
   input  wire logic                         sim_req_bus,
   input  wire logic [fvse_pkg::VALUE_W-1:0] sim_value,
   input  wire logic [7:0]                   sim_status,
   input  wire logic                         param_wr_req,
   // fieldbus value
   output logic [fvse_pkg::VALUE_W-1:0]      value_out_r,
   output logic [7:0]                        status_out_r,
   output logic                              sim_active_r,
   output logic                              param_wr_ack_r,
   output logic                              param_wr_reject_r,
   // indicators
   output logic                              led_red_r,
   output logic                              led_green_r,
   output logic                              led_orange_r,
   // node identifier serial out
   output logic                              id_bit_r,
   output logic                              id_strobe_r
);

   // =========================================================
   // status encoding
   logic [1:0] qual_nxt;
   logic [3:0] sub_nxt;
   logic [1:0] lim_nxt;
   logic [1:0] lim_dir;
   logic       alarm_crit;

   // limit direction: constant outranks a direction
   always_comb begin
      if (lim_const) begin
         lim_dir = fvse_pkg::LIM_CONST;
      end else if (lim_high) begin
         lim_dir = fvse_pkg::LIM_HIGH;
      end else if (lim_low) begin
         lim_dir = fvse_pkg::LIM_LOW;
      end else begin
         lim_dir = fvse_pkg::LIM_NONE;
      end
   end

   assign alarm_crit = (alarm_prio >= fvse_pkg::ALARM_CRIT_PRIO);

   // bad outranks uncertain outranks good; within each, the
   // condition that explains most about the value comes first
   always_comb begin
      qual_nxt = fvse_pkg::Q_GOOD_NC;
      sub_nxt  = fvse_pkg::GS_NONE;
      lim_nxt  = fvse_pkg::LIM_NONE;
      if (blk_oos) begin
         qual_nxt = fvse_pkg::Q_BAD;
         sub_nxt  = fvse_pkg::BS_OOS;
      end else if (dev_fail) begin
         qual_nxt = fvse_pkg::Q_BAD;
         sub_nxt  = fvse_pkg::BS_DEV_FAIL;
      end else if (sens_fail) begin
         qual_nxt = fvse_pkg::Q_BAD;
         sub_nxt  = fvse_pkg::BS_SENS_FAIL;
         lim_nxt  = lim_dir;
      end else if (cfg_err) begin
         qual_nxt = fvse_pkg::Q_BAD;
         sub_nxt  = fvse_pkg::BS_CONFIG;
      end else if (not_linked) begin
         qual_nxt = fvse_pkg::Q_BAD;
         sub_nxt  = fvse_pkg::BS_NOT_LINK;
      end else if (comm_never) begin
         qual_nxt = fvse_pkg::Q_BAD;
         sub_nxt  = fvse_pkg::BS_COMM_NONE;
      end else if (comm_lost) begin
         qual_nxt = fvse_pkg::Q_BAD;
         sub_nxt  = fvse_pkg::BS_COMM_LAST;
      end else if (bad_other) begin
         qual_nxt = fvse_pkg::Q_BAD;
         sub_nxt  = fvse_pkg::BS_NONSPEC;
      end else if (at_sens_limit) begin
         qual_nxt = fvse_pkg::Q_UNCERT;
         sub_nxt  = fvse_pkg::US_SENS_CONV;
         lim_nxt  = lim_dir;
      end else if (low_accuracy) begin
         qual_nxt = fvse_pkg::Q_UNCERT;
         sub_nxt  = fvse_pkg::US_SENS_CONV;
      end else if (range_viol) begin
         qual_nxt = fvse_pkg::Q_UNCERT;
         sub_nxt  = fvse_pkg::US_RANGE;
         lim_nxt  = lim_dir;
      end else if (subnormal) begin
         qual_nxt = fvse_pkg::Q_UNCERT;
         sub_nxt  = fvse_pkg::US_SUBNORMAL;
      end else if (initial_val) begin
         qual_nxt = fvse_pkg::Q_UNCERT;
         sub_nxt  = fvse_pkg::US_INITIAL;
      end else if (substitute) begin
         qual_nxt = fvse_pkg::Q_UNCERT;
         sub_nxt  = fvse_pkg::US_SUBST;
      end else if (last_usable) begin
         qual_nxt = fvse_pkg::Q_UNCERT;
         sub_nxt  = fvse_pkg::US_LAST_USE;
      end else if (uncert_other) begin
         qual_nxt = fvse_pkg::Q_UNCERT;
         sub_nxt  = fvse_pkg::US_NONSPEC;
      end else if (cascade) begin
         // alarms are not shown on the cascade path
         qual_nxt = fvse_pkg::Q_GOOD_C;
      end else if (alarm_unack) begin
         if (alarm_is_block) begin
            sub_nxt = fvse_pkg::GS_UNACK_BLK;
         end else if (alarm_crit) begin
            sub_nxt = fvse_pkg::GS_UNACK_CRIT;
         end else begin
            sub_nxt = fvse_pkg::GS_UNACK_ADV;
         end
      end else if (alarm_active) begin
         if (alarm_is_block) begin
            sub_nxt = fvse_pkg::GS_ACT_BLOCK;
         end else if (alarm_crit) begin
            sub_nxt = fvse_pkg::GS_ACT_CRIT;
         end else begin
            sub_nxt = fvse_pkg::GS_ACT_ADV;
         end
      end
   end

   // =========================================================
   // simulate: the jumper gates both request sources
   logic sim_nxt;
   assign sim_nxt = ff_jumper & (sim_req_sw | sim_req_bus);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         sim_active_r <= 1'b0;
      end else begin
         sim_active_r <= sim_nxt;
      end
   end

   // =========================================================
   // value and status out, same cycle so they never tear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         value_out_r  <= '0;
         status_out_r <= fvse_pkg::STATUS_RST;
      end else if (sim_nxt) begin
         value_out_r  <= sim_value;
         status_out_r <= sim_status;
      end else begin
         value_out_r  <= primary_measured_value;
         status_out_r <= {qual_nxt, sub_nxt, lim_nxt};
      end
   end

   // =========================================================
   // write protect
   always_ff @(posedge core_clk) begin
      if (srst) begin
         param_wr_ack_r    <= 1'b0;
         param_wr_reject_r <= 1'b0;
      end else begin
         param_wr_ack_r    <= param_wr_req & ~ff_jumper;
         param_wr_reject_r <= param_wr_req & ff_jumper;
      end
   end

   // =========================================================
   // commissioning identifier
   logic id_busy;

   fvse_id_sender #(
      .WIDTH   (fvse_pkg::NODE_ID_W),
      .BIT_CYC (fvse_pkg::ID_BIT_CYC)
   ) u_id_sender (
      .core_clk    (core_clk),
      .srst        (srst),
      .start       (commission_req),
      .node_id     (UNIQUE_NODE_ID),
      .busy_r      (id_busy),
      .tx_bit_r    (id_bit_r),
      .tx_strobe_r (id_strobe_r)
   );

   // =========================================================
   // indicators
   logic blink;

   fvse_blink #(
      .HALF_CYC (BLINK_HALF_CYC)
   ) u_blink (
      .core_clk (core_clk),
      .srst     (srst),
      .blink_r  (blink)
   );

   // green is off while an error stands: it only claims correct operation
   always_ff @(posedge core_clk) begin
      if (srst) begin
         led_red_r    <= 1'b0;
         led_green_r  <= 1'b0;
         led_orange_r <= 1'b0;
      end else begin
         led_red_r    <= dev_error;
         led_green_r  <= ~dev_error & (~dev_warning | blink);
         led_orange_r <= id_busy;
      end
   end

   // =========================================================
   // checks
   oos_code_a: assert property (@(posedge core_clk) disable iff (srst)
      blk_oos && !sim_nxt |=> status_out_r == 8'h1c)
      else $error("out of service not coded as bad 7");

   bad_prio_a: assert property (@(posedge core_clk) disable iff (srst)
      !blk_oos && dev_fail && !sim_nxt |=> status_out_r[7:2] == 6'h03)
      else $error("device failure not reported as bad 3");

   sens_lim_a: assert property (@(posedge core_clk) disable iff (srst)
      !blk_oos && !dev_fail && sens_fail && lim_high && !lim_const && !sim_nxt
      |=> status_out_r == 8'h12)
      else $error("sensor failure high limit wrong");

   acc_nolim_a: assert property (@(posedge core_clk) disable iff (srst)
      (qual_nxt == 2'h1) && !at_sens_limit && low_accuracy && !sim_nxt
      |=> status_out_r == 8'h50)
      else $error("reduced accuracy must set no limit bits");

   good_crit_a: assert property (@(posedge core_clk) disable iff (srst)
      (qual_nxt == 2'h2) && alarm_unack && !alarm_is_block && alarm_prio == 4'h8
      && !sim_nxt |=> status_out_r == 8'h98)
      else $error("unacknowledged critical alarm wrong");

   sim_gate_a: assert property (@(posedge core_clk) disable iff (srst)
      !ff_jumper |=> !sim_active_r)
      else $error("simulation active without jumper");

   sim_data_a: assert property (@(posedge core_clk) disable iff (srst)
      sim_active_r |-> value_out_r == $past(sim_value) && status_out_r == $past(sim_status))
      else $error("simulation values not sent");

   wr_prot_a: assert property (@(posedge core_clk) disable iff (srst)
      param_wr_req && ff_jumper |=> param_wr_reject_r && !param_wr_ack_r)
      else $error("write accepted with jumper fitted");

   red_led_a: assert property (@(posedge core_clk) disable iff (srst)
      dev_error |=> led_red_r && !led_green_r)
      else $error("error not shown on red indicator");

   green_on_a: assert property (@(posedge core_clk) disable iff (srst)
      !dev_error && !dev_warning |=> led_green_r)
      else $error("green not steady in correct operation");

   id_send_a: assert property (@(posedge core_clk) disable iff (srst)
      commission_req && !id_busy |=> id_busy ##1 led_orange_r)
      else $error("identifier transmission not started");

   wr_ack_a: assert property (@(posedge core_clk) disable iff (srst)
      param_wr_req && !ff_jumper |=> param_wr_ack_r && !param_wr_reject_r)
      else $error("write refused without jumper");

   casc_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
      (qual_nxt == 2'h3) && (alarm_active || alarm_unack) && !sim_nxt |=> status_out_r == 8'hc0)
      else $error("alarm shown on cascade path");

   orange_busy_a: assert property (@(posedge core_clk) disable iff (srst)
      id_busy |=> led_orange_r)
      else $error("orange not lit while sending identifier");

   lim_const_a: assert property (@(posedge core_clk) disable iff (srst)
      !blk_oos && !dev_fail && sens_fail && lim_const && !sim_nxt |=> status_out_r[1:0] == 2'h3)
      else $error("constant limit not coded as 3");

   range_lim_a: assert property (@(posedge core_clk) disable iff (srst)
      (qual_nxt == 2'h1) && !at_sens_limit && !low_accuracy && range_viol && lim_high
      && !lim_const && !sim_nxt |=> status_out_r == 8'h56)
      else $error("range violation high limit wrong");

endmodule

// ===== tb/fvse_master_model.sv
/*
 * far-side model: gathers the serial node identifier as the network
 * controller would. assumes the strobe is one cycle with the bit beside it.
 */
`timescale 1ns/1ns
module fvse_master_model (
   // clock and reset
   input  wire logic   core_clk,
   input  wire logic   srst,
   // identifier serial in
   input  wire logic   id_bit,
   input  wire logic   id_strobe,
   // collected identifier
   output logic [47:0] rx_id,
   output int          rx_cnt
);
   // =========================================================
   // msb arrives first, so shift in from the right
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rx_id  <= '0;
         rx_cnt <= 0;
      end else if (id_strobe) begin
         rx_id  <= {rx_id[46:0], id_bit};
         rx_cnt <= rx_cnt + 1;
      end
   end
endmodule

// ===== tb/test_fvse_top.sv
/*
 * bench for the status encoder: status tables, simulate and write
 * protect, indicators, identifier. assumes the master model is compiled.
 */
`timescale 1ns/1ns
module test_fvse_top;
   localparam logic [47:0] NODE_ID = 48'h5a3c9e170b42; // arbitrary value
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic [15:0] c = 16'h0;
   logic [2:0]  lim = 3'h0;
   logic [15:0] pv = 16'h1234, sim_val = 16'hbeef, vo;
   logic [7:0]  sim_st = 8'h5d, so;
   logic [3:0]  prio = 4'h0;
   logic        casc = 1'b0, a_act = 1'b0, a_unack = 1'b0, a_blk = 1'b0;
   logic        err = 1'b0, warn = 1'b0, com = 1'b0, wr = 1'b0;
   logic        jmp = 1'b0, s_sw = 1'b0, s_bus = 1'b0;
   logic        sim_a, ack, rej, red, grn, org, idb, ids;
   logic [47:0] rx_id;
   int          rx_cnt, n, cyc = 0, err_total = 0, total_checks = 0;
   // priority order high to low is bit 15 down to bit 0
   logic [3:0]  sub_t [16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h5, 4'h4, 4'h4,
                               4'h0, 4'h5, 4'h6, 4'h2, 4'h1, 4'h4, 4'h3, 4'h7};
   logic [6:0]  al_t [7] = '{7'h00, 7'h39, 7'h27, 7'h28, 7'h70, 7'h67, 7'h6f};
   logic [2:0]  sm_t [3] = '{3'h2, 3'h5, 3'h6};

   always #2 core_clk = ~core_clk;

   fvse_top #(.BLINK_HALF_CYC(4), .UNIQUE_NODE_ID(NODE_ID)) u_dut (
      .core_clk(core_clk), .srst(srst), .primary_measured_value(pv),
      .blk_oos(c[15]), .dev_fail(c[14]), .sens_fail(c[13]), .cfg_err(c[12]),
      .not_linked(c[11]), .comm_never(c[10]), .comm_lost(c[9]), .bad_other(c[8]),
      .at_sens_limit(c[7]), .low_accuracy(c[6]), .range_viol(c[5]), .subnormal(c[4]),
      .initial_val(c[3]), .substitute(c[2]), .last_usable(c[1]), .uncert_other(c[0]),
      .lim_low(lim[0]), .lim_high(lim[1]), .lim_const(lim[2]), .cascade(casc),
      .alarm_active(a_act), .alarm_unack(a_unack), .alarm_is_block(a_blk),
      .alarm_prio(prio), .dev_error(err), .dev_warning(warn), .commission_req(com),
      .ff_jumper(jmp), .sim_req_sw(s_sw), .sim_req_bus(s_bus), .sim_value(sim_val),
      .sim_status(sim_st), .param_wr_req(wr), .value_out_r(vo), .status_out_r(so),
      .sim_active_r(sim_a), .param_wr_ack_r(ack), .param_wr_reject_r(rej),
      .led_red_r(red), .led_green_r(grn), .led_orange_r(org), .id_bit_r(idb),
      .id_strobe_r(ids));

   fvse_master_model u_mst (.core_clk(core_clk), .srst(srst), .id_bit(idb),
      .id_strobe(ids), .rx_id(rx_id), .rx_cnt(rx_cnt));

   task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task results;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // =========================================================
   // hang guard: whole run is about 12400 cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 20000) begin
         err_total++;
         results();
      end
   end

   initial begin
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      lim <= 3'h2;
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk);
         c <= (16'h1 << i) | ((16'h1 << i) - 16'h1);
         @(posedge core_clk);
         #1;
         chk("status", so, {(i > 7) ? fvse_pkg::Q_BAD : fvse_pkg::Q_UNCERT, sub_t[i],
             (i == 13 || i == 7 || i == 5) ? fvse_pkg::LIM_HIGH : fvse_pkg::LIM_NONE});
      end
      for (int j = 0; j < 4; j++) begin
         @(posedge core_clk);
         c <= 16'h2000;
         lim <= 3'((1 << j) - 1);
         @(posedge core_clk);
         #1;
         chk("limit", so, {fvse_pkg::Q_BAD, fvse_pkg::BS_SENS_FAIL, 2'(j)});
      end
      @(posedge core_clk);
      c <= 16'h0;
      {casc, a_act, a_unack} <= 3'h7;
      @(posedge core_clk);
      #1;
      chk("cascade", so, {fvse_pkg::Q_GOOD_C, 6'h00});
      for (int k = 0; k < 7; k++) begin
         @(posedge core_clk);
         casc <= 1'b0;
         {a_unack, a_act, a_blk, prio} <= al_t[k];
         @(posedge core_clk);
         #1;
         chk("alarm", so, {fvse_pkg::Q_GOOD_NC, 4'(k), fvse_pkg::LIM_NONE});
      end
      for (int m = 0; m < 3; m++) begin
         @(posedge core_clk);
         {a_unack, a_act, a_blk, prio} <= 7'h00;
         {jmp, s_sw, s_bus} <= sm_t[m];
         @(posedge core_clk);
         #1;
         chk("sim", sim_a, m > 0);
         chk("simval", vo, (m > 0) ? sim_val : pv);
         chk("simst", so, (m > 0) ? sim_st : 8'h80);
      end
      @(posedge core_clk);
      {jmp, s_sw, wr} <= 3'h1;
      @(posedge core_clk);
      wr <= 1'b0;
      #1;
      chk("ack", {ack, rej}, 2'h2);
      @(posedge core_clk);
      jmp <= 1'b1;
      wr <= 1'b1;
      @(posedge core_clk);
      #1;
      chk("rej1", {ack, rej}, 2'h1);
      @(posedge core_clk);
      wr <= 1'b0;
      #1;
      chk("rej2", {ack, rej}, 2'h1);
      @(posedge core_clk);
      #1;
      chk("rej3", {ack, rej}, 2'h0);
      chk("green", grn, 1'b1);
      @(posedge core_clk);
      err <= 1'b1;
      @(posedge core_clk);
      #1;
      chk("red", {red, grn}, 2'h2);
      @(posedge core_clk);
      err <= 1'b0;
      warn <= 1'b1;
      n = 0;
      repeat (16) begin
         @(posedge core_clk);
         #1;
         n = n + int'(grn);
      end
      chk("flash", 48'(n), 48'd8);
      @(posedge core_clk);
      warn <= 1'b0;
      com <= 1'b1;
      @(posedge core_clk);
      com <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      chk("orange", org, 1'b1);
      @(posedge core_clk);
      com <= 1'b1;
      @(posedge core_clk);
      com <= 1'b0;
      n = 0;
      #1;
      while (org === 1'b1 && n < 13000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      repeat (300) @(posedge core_clk);
      #1;
      chk("node id", rx_id, NODE_ID);
      chk("bits", 48'(rx_cnt), 48'd48);
      chk("org off", org, 1'b0);
      results();
   end
endmodule
